// File: src/mswh_handler.sv
/*
  single coil / single register write query handler: collects an rtu frame,
  checks crc and address, applies the write, echoes or sends an exception.
  assumes an outer byte receiver that flags the inter-frame gap with rx_frame_end
  (never in the same cycle as rx_valid) and a byte transmitter with tx_valid/tx_ready.
*/
// Contract
// - function 05h writes one coil chosen by the coil number field.
// - coil data ff00h switches on, 0000h switches off.
// - function 06h writes one 16-bit value, upper byte first, to one register.
// - transmitted item number is one less; device adds one before writing.
// - broadcast single writes never produce any reply frame.
// - a write that cannot be done returns an exception reply instead.
// - frame is address, function, item, data, then crc-16.
// - coil 1 is the run command, on starts and off stops.
// - run command acts only while source select equals 03.
// - register 1203h holds base frequency, unsigned, one hertz per step.
`timescale 1ns/1ps
module mswh_handler
  import mswh_pkg::*;
(
  input  wire logic        ref_clk,                    // system clock, 125 MHz
  input  wire logic        rst,                        // synchronous reset, active high
  input  wire logic [7:0]  own_addr,                   // this slave's address
  input  wire logic        rx_valid,                   // received byte strobe
  input  wire logic [7:0]  rx_data,                    // received byte
  input  wire logic        rx_frame_end,               // silent gap seen, frame closed
  output logic             tx_valid,                   // reply byte offered
  output logic [7:0]       tx_data,                    // reply byte
  output logic             tx_last,                    // last byte of reply
  input  wire logic        tx_ready,                   // transmitter takes byte
  input  wire logic [7:0]  run_command_source_select,  // run source setting
  output logic             run_coil,                   // coil 1 state
  output logic             run_cmd,                    // effective run command
  output logic [15:0]      base_frequency_setting      // base frequency in hertz
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  mswh_state_t  state_q,   state_d;
  logic [3:0]   cnt_q,     cnt_d;
  logic [15:0]  crc_q,     crc_d;
  logic [7:0]   buf_q [FRAME_LEN];
  logic [7:0]   buf_d [FRAME_LEN];
  logic [3:0]   idx_q,     idx_d;
  logic [15:0]  txcrc_q,   txcrc_d;
  logic         exc_q,     exc_d;
  logic [7:0]   code_q,    code_d;
  logic         txv_q,     txv_d;
  logic [7:0]   txd_q,     txd_d;
  logic         coil_q,    coil_d;
  logic [15:0]  freq_q,    freq_d;

  // decoded query fields
  logic [7:0]   fn;
  logic [15:0]  item;
  logic [15:0]  wdata;
  logic         bcast;
  logic         dec_exc;
  logic [7:0]   dec_code;
  logic         wr_coil;
  logic         coil_val;
  logic         wr_freq;

  // picks the reply byte at position i
  function automatic logic [7:0] reply_byte(input logic [3:0] i, input logic x,
                                            input logic [7:0] cd, input logic [15:0] c);
    logic [7:0] b;
    b = buf_q[i[2:0]];
    if (x)
    begin
      unique case (i)
        4'h0:    b = buf_q[0];
        4'h1:    b = buf_q[1] | EXC_FLAG;
        4'h2:    b = cd;
        4'h3:    b = c[7:0];
        default: b = c[15:8];
      endcase
    end
    return b;
  endfunction

  // ----------------------------------------------------------------
  // query decode
  // ----------------------------------------------------------------
  // field split and item number adjustment
  always_comb
  begin
    fn       = buf_q[1];
    item     = {buf_q[2], buf_q[3]} + ITEM_OFFSET;
    wdata    = {buf_q[4], buf_q[5]};
    bcast    = (buf_q[0] == BCAST_ADDR);
    dec_exc  = 1'b0;
    dec_code = 8'h00;
    wr_coil  = 1'b0;
    coil_val = 1'b0;
    wr_freq  = 1'b0;
    if (fn == FN_WR_COIL)
    begin
      if (item != RUN_COIL_NUM)
      begin
        dec_exc  = 1'b1;
        dec_code = EXC_ILL_ADDR;
      end
      else if ((buf_q[4] == COIL_ON_HI || buf_q[4] == COIL_OFF_HI) && buf_q[5] == COIL_DATA_LO)
      begin
        wr_coil  = 1'b1;
        coil_val = (buf_q[4] == COIL_ON_HI);
      end
      else
      begin
        dec_exc  = 1'b1;
        dec_code = EXC_ILL_DATA;
      end
    end
    else if (fn == FN_WR_REG)
    begin
      if (item == BASE_FREQ_REG)
      begin
        wr_freq  = 1'b1;
      end
      else
      begin
        dec_exc  = 1'b1;
        dec_code = EXC_ILL_ADDR;
      end
    end
    else
    begin
      dec_exc  = 1'b1;
      dec_code = EXC_ILL_FUNC;
    end
  end

  // ----------------------------------------------------------------
  // drive settings
  // ----------------------------------------------------------------
  // coil and base frequency update in the execute cycle
  always_comb
  begin
    coil_d = (state_q == ST_EXEC && wr_coil) ? coil_val : coil_q;
    freq_d = (state_q == ST_EXEC && wr_freq) ? wdata : freq_q;
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      coil_q <= RUN_COIL_RST;
      freq_q <= BASE_FREQ_RST;
    end
    else
    begin
      coil_q <= coil_d;
      freq_q <= freq_d;
    end
  end

  // ----------------------------------------------------------------
  // frame engine
  // ----------------------------------------------------------------
  // receive, execute and send
  always_comb
  begin
    state_d = state_q;
    cnt_d   = cnt_q;
    crc_d   = crc_q;
    buf_d   = buf_q;
    idx_d   = idx_q;
    txcrc_d = txcrc_q;
    exc_d   = exc_q;
    code_d  = code_q;
    txv_d   = txv_q;
    txd_d   = txd_q;
    unique case (state_q)
      ST_RECV:
      begin
        if (rx_valid)
        begin
          if (cnt_q < FRAME_LEN)
          begin
            buf_d[cnt_q[2:0]] = rx_data;
          end
          cnt_d = (cnt_q == CNT_OVER) ? CNT_OVER : cnt_q + 4'h1;
          crc_d = mswh_crc_byte(crc_q, rx_data);
        end
        else if (rx_frame_end)
        begin
          cnt_d = 4'h0;
          crc_d = CRC_INIT;
          if (cnt_q == FRAME_LEN && crc_q == 16'h0000 &&
              (buf_q[0] == own_addr || buf_q[0] == BCAST_ADDR))
          begin
            state_d = ST_EXEC;
          end
        end
      end
      ST_EXEC:
      begin
        if (bcast)
        begin
          state_d = ST_RECV;
        end
        else
        begin
          state_d = ST_SEND;
          exc_d   = dec_exc;
          code_d  = dec_code;
          idx_d   = 4'h0;
          txcrc_d = CRC_INIT;
          txv_d   = 1'b1;
          txd_d   = reply_byte(4'h0, dec_exc, dec_code, CRC_INIT);
        end
      end
      ST_SEND:
      begin
        if (tx_ready)
        begin
          txcrc_d = (idx_q < 4'h3) ? mswh_crc_byte(txcrc_q, txd_q) : txcrc_q; // head bytes only
          if (tx_last)
          begin
            txv_d   = 1'b0;
            state_d = ST_RECV;
          end
          else
          begin
            idx_d = idx_q + 4'h1;
            txd_d = reply_byte(idx_q + 4'h1, exc_q, code_q, txcrc_d);
          end
        end
      end
      default:
      begin
        state_d = ST_RECV;
        txv_d   = 1'b0;
      end
    endcase
  end

  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      state_q <= ST_RECV;
      cnt_q   <= 4'h0;
      crc_q   <= CRC_INIT;
      buf_q   <= '{default: 8'h00};
      idx_q   <= 4'h0;
      txcrc_q <= CRC_INIT;
      exc_q   <= 1'b0;
      code_q  <= 8'h00;
      txv_q   <= 1'b0;
      txd_q   <= 8'h00;
    end
    else
    begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      crc_q   <= crc_d;
      buf_q   <= buf_d;
      idx_q   <= idx_d;
      txcrc_q <= txcrc_d;
      exc_q   <= exc_d;
      code_q  <= code_d;
      txv_q   <= txv_d;
      txd_q   <= txd_d;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  // reply stream and drive settings
  assign tx_valid               = txv_q;
  assign tx_data                = txd_q;
  assign tx_last                = txv_q && (idx_q == (exc_q ? EXC_LEN : FRAME_LEN) - 4'h1);
  assign run_coil               = coil_q;
  assign run_cmd                = coil_q && (run_command_source_select == SRC_SERIAL);
  assign base_frequency_setting = freq_q;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);

  coil_on_a: assert property (
    state_q == ST_EXEC && fn == FN_WR_COIL && item == RUN_COIL_NUM && wdata == 16'hff00
    |=> run_coil) else $error("coil not set by ff00");
  coil_off_a: assert property (
    state_q == ST_EXEC && fn == FN_WR_COIL && item == RUN_COIL_NUM && wdata == 16'h0000
    |=> !run_coil) else $error("coil not cleared by 0000");
  reg_write_a: assert property (
    state_q == ST_EXEC && fn == FN_WR_REG && {buf_q[2], buf_q[3]} == 16'h1202
    |=> base_frequency_setting == $past(wdata)) else $error("base frequency not written");
  item_offset_a: assert property (
    state_q == ST_EXEC && fn == FN_WR_REG && {buf_q[2], buf_q[3]} != 16'h1202
    |=> $stable(base_frequency_setting) && (!tx_valid || (exc_q && code_q == EXC_ILL_ADDR)))
    else $error("wrong register number accepted");
  bcast_quiet_a: assert property (
    state_q == ST_EXEC && bcast |=> !tx_valid [*2]) else $error("reply to broadcast");
  exc_reply_a: assert property (
    state_q == ST_EXEC && !bcast && dec_exc
    |=> tx_valid && exc_q && code_q == $past(dec_code) && tx_data == buf_q[0])
    else $error("no exception reply");
  frame_len_a: assert property (
    tx_valid && tx_ready && tx_last |-> idx_q == (exc_q ? 4'h4 : 4'h7) ##1 !tx_valid)
    else $error("reply length wrong");
  run_start_a: assert property (
    state_q == ST_EXEC && wr_coil && coil_val && run_command_source_select == SRC_SERIAL
    |=> run_cmd) else $error("run command not started");
  run_gate_a: assert property (
    run_command_source_select != SRC_SERIAL |-> !run_cmd) else $error("run without serial");
  echo_copy_a: assert property (
    tx_valid && !exc_q |-> tx_data == buf_q[idx_q[2:0]]) else $error("echo differs");
  crc_drop_a: assert property (
    state_q == ST_RECV && rx_frame_end && crc_q != 16'h0000
    |=> state_q == ST_RECV && !tx_valid) else $error("bad crc accepted");
  coil_ack_c:   cover property (state_q == ST_EXEC && wr_coil && !bcast ##1 tx_valid);
  reg_ack_c:    cover property (state_q == ST_EXEC && wr_freq && !bcast ##1 tx_valid);
  exc_sent_c:   cover property (tx_valid && tx_ready && tx_last && exc_q);
  bcast_done_c: cover property (state_q == ST_EXEC && bcast && wr_freq);

endmodule // mswh_handler

// File: src/mswh_pkg.sv
/*
  shared constants, state encoding and crc step for the single-write query handler.
  assumes modbus rtu byte framing; no register bus, no second clock.
*/
package mswh_pkg;

  // ----------------------------------------------------------------
  // function codes, addresses and exception codes
  // ----------------------------------------------------------------
  localparam logic [7:0]  FN_WR_COIL     = 8'h05;
  localparam logic [7:0]  FN_WR_REG      = 8'h06;
  localparam logic [7:0]  BCAST_ADDR     = 8'h00;
  localparam logic [7:0]  EXC_FLAG       = 8'h80;
  localparam logic [7:0]  EXC_ILL_FUNC   = 8'h01;
  localparam logic [7:0]  EXC_ILL_ADDR   = 8'h02;
  localparam logic [7:0]  EXC_ILL_DATA   = 8'h03;
  localparam logic [7:0]  COIL_ON_HI     = 8'hff;
  localparam logic [7:0]  COIL_OFF_HI    = 8'h00;
  localparam logic [7:0]  COIL_DATA_LO   = 8'h00;
  localparam logic [7:0]  SRC_SERIAL     = 8'h03;

  // ----------------------------------------------------------------
  // item numbers, reset values, frame sizes
  // ----------------------------------------------------------------
  localparam logic [15:0] ITEM_OFFSET    = 16'h0001;
  localparam logic [15:0] RUN_COIL_NUM   = 16'h0001;
  localparam logic [15:0] BASE_FREQ_REG  = 16'h1203;
  localparam logic [15:0] BASE_FREQ_RST  = 16'h0032;
  localparam logic        RUN_COIL_RST   = 1'b0;
  localparam logic [15:0] CRC_INIT       = 16'hffff;
  localparam logic [15:0] CRC_POLY       = 16'ha001;
  localparam logic [3:0]  FRAME_LEN      = 4'h8;
  localparam logic [3:0]  EXC_LEN        = 4'h5;
  localparam logic [3:0]  CNT_OVER       = 4'h9;

  // ----------------------------------------------------------------
  // frame engine states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_RECV = 3'b001,
    ST_EXEC = 3'b010,
    ST_SEND = 3'b100
  } mswh_state_t;

  // one byte through the reflected crc-16 (lsb first)
  function automatic logic [15:0] mswh_crc_byte(input logic [15:0] crc, input logic [7:0] b);
    logic [15:0] c;
    c = crc ^ {8'h00, b};
    for (int k = 0; k < 8; k++)
    begin
      c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction

endpackage

// File: tb/mswh_master.sv
/*
  behavioural bus master: sends query bytes, takes reply bytes.
  assumes the slave handshake tx_valid/tx_ready and one clock.
*/
`timescale 1ns/1ps
module mswh_master (
  input  wire logic       ref_clk,      // system clock
  output logic            rx_valid,     // byte strobe
  output logic [7:0]      rx_data,      // query byte
  output logic            rx_frame_end, // gap after frame
  input  wire logic       tx_valid,     // reply byte offered
  input  wire logic [7:0] tx_data,      // reply byte
  input  wire logic       tx_last,      // last reply byte
  output logic            tx_ready      // byte accepted
);
  logic [7:0] rsp[$];
  int         last_at = -1;
  logic       slow = 1'b0;

  initial
  begin
    rx_valid = 1'b0;
    rx_data = 8'h00;
    rx_frame_end = 1'b0;
    tx_ready = 1'b0;
  end

  // stalls every other cycle when slow
  always @(negedge ref_clk)
    tx_ready <= slow ? ~tx_ready : 1'b1;

  // reply capture
  always @(posedge ref_clk)
  begin
    if (tx_valid && tx_ready && tx_last)
      last_at = rsp.size();
    if (tx_valid && tx_ready)
      rsp.push_back(tx_data);
  end

  task automatic send(input logic [7:0] f[8]);
    for (int i = 0; i < 8; i++)
    begin
      @(negedge ref_clk);
      rx_valid = 1'b1;
      rx_data = f[i];
    end
    @(negedge ref_clk);
    rx_valid = 1'b0;
    rx_data = ~rx_data; // no stale byte after release
    rx_frame_end = 1'b1;
    @(negedge ref_clk);
    rx_frame_end = 1'b0;
  endtask

  task automatic get_reply(input int n, input int limit);
    int t;
    t = 0;
    while ((n == 0 || rsp.size() < n) && t < limit)
    begin
      @(negedge ref_clk);
      t++;
    end
    repeat (4) @(negedge ref_clk);
  endtask
endmodule // mswh_master

// File: tb/testbench.sv
/*
  self-checking bench for the single-write query handler.
  assumes mswh_pkg and the master model; one 125 MHz clock.
*/
`timescale 1ns/1ps
module testbench
  import mswh_pkg::*;
;
  logic        ref_clk = 1'b0;
  logic        rst = 1'b1;
  logic [7:0]  own_addr = 8'h0a;
  logic [7:0]  src = SRC_SERIAL;
  logic        rx_valid, rx_frame_end, tx_valid, tx_last, tx_ready;
  logic        run_coil, run_cmd;
  logic [7:0]  rx_data, tx_data;
  logic [15:0] base_freq;
  int          fails = 0;
  int          tests_run = 0;
  int          cyc = 0;

  mswh_handler dut (.ref_clk(ref_clk), .rst(rst), .own_addr(own_addr),
    .rx_valid(rx_valid), .rx_data(rx_data), .rx_frame_end(rx_frame_end),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_last(tx_last), .tx_ready(tx_ready),
    .run_command_source_select(src), .run_coil(run_coil), .run_cmd(run_cmd),
    .base_frequency_setting(base_freq));

  mswh_master m (.ref_clk(ref_clk), .rx_valid(rx_valid), .rx_data(rx_data),
    .rx_frame_end(rx_frame_end), .tx_valid(tx_valid), .tx_data(tx_data),
    .tx_last(tx_last), .tx_ready(tx_ready));

  initial
  begin
    forever #4 ref_clk = ~ref_clk;
  end

  task automatic final_report();
    if (fails == 0 && tests_run > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  always @(posedge ref_clk)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      fails++;
      final_report();
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      fails++;
      $display("mismatch at %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // reflected crc over the first n bytes
  function automatic logic [15:0] crc16(input logic [7:0] f[8], input int n);
    logic [15:0] c;
    c = CRC_INIT;
    for (int i = 0; i < n; i++)
    begin
      c ^= {8'h00, f[i]};
      for (int k = 0; k < 8; k++)
        c = c[0] ? ((c >> 1) ^ CRC_POLY) : (c >> 1);
    end
    return c;
  endfunction

  // kind 0 silent, 1 echo, 2 exception with code xc
  task automatic query(input logic [7:0] a, fn, input logic [15:0] it, dt,
                       input bit bad, input int kind, input logic [7:0] xc);
    logic [7:0]  f[8];
    logic [7:0]  e[8];
    logic [15:0] c;
    int          n;
    f = '{a, fn, it[15:8], it[7:0], dt[15:8], dt[7:0], 8'h00, 8'h00};
    c = crc16(f, 6) ^ {15'h0, bad};
    f[6] = c[7:0];
    f[7] = c[15:8];
    e = f;
    n = (kind == 0) ? 0 : (kind == 1) ? 8 : 5;
    if (kind == 2)
    begin
      e[1] = fn | EXC_FLAG;
      e[2] = xc;
      c = crc16(e, 3);
      e[3] = c[7:0];
      e[4] = c[15:8];
    end
    m.rsp.delete();
    m.last_at = -1;
    m.send(f);
    m.get_reply(n, 60);
    // resend once on a short or missing reply
    if (n > 0 && m.rsp.size() < n)
    begin
      m.rsp.delete();
      m.last_at = -1;
      m.send(f);
      m.get_reply(n, 60);
    end
    chk(16'(m.rsp.size()), 16'(n));
    if (n > 0)
      chk(16'(m.last_at), 16'(n - 1));
    for (int i = 0; i < n && i < m.rsp.size(); i++)
      chk({8'h00, m.rsp[i]}, {8'h00, e[i]});
  endtask

  task automatic t_coil_on();
    query(8'h0a, FN_WR_COIL, 16'h0000, 16'hff00, 1'b0, 1, 8'h00);
    chk({15'h0, run_coil}, 16'h0001);
    chk({15'h0, run_cmd}, 16'h0001);
  endtask

  task automatic t_source();
    src = 8'h00;
    @(negedge ref_clk);
    chk({15'h0, run_cmd}, 16'h0000);
    src = SRC_SERIAL;
    @(negedge ref_clk);
    chk({15'h0, run_cmd}, 16'h0001);
  endtask

  task automatic t_coil_off_slow();
    m.slow = 1'b1;
    query(8'h0a, FN_WR_COIL, 16'h0000, 16'h0000, 1'b0, 1, 8'h00);
    m.slow = 1'b0;
    chk({15'h0, run_coil}, 16'h0000);
  endtask

  task automatic t_register();
    query(8'h0a, FN_WR_REG, 16'h1202, 16'h0064, 1'b0, 1, 8'h00);
    chk(base_freq, 16'h0064);
  endtask

  task automatic t_broadcast();
    query(BCAST_ADDR, FN_WR_REG, 16'h1202, 16'h0032, 1'b0, 0, 8'h00);
    chk(base_freq, 16'h0032);
  endtask

  task automatic t_dropped();
    query(8'h0a, FN_WR_REG, 16'h1202, 16'h0123, 1'b1, 0, 8'h00);
    query(8'h0b, FN_WR_REG, 16'h1202, 16'h0123, 1'b0, 0, 8'h00);
    chk(base_freq, 16'h0032);
  endtask

  task automatic t_exceptions();
    query(8'h0a, FN_WR_COIL, 16'h0000, 16'h1234, 1'b0, 2, EXC_ILL_DATA);
    query(8'h0a, 8'h07, 16'h0000, 16'h0000, 1'b0, 2, EXC_ILL_FUNC);
    query(8'h0a, FN_WR_REG, 16'h1203, 16'h0010, 1'b0, 2, EXC_ILL_ADDR);
    query(8'h0a, FN_WR_COIL, 16'h0001, 16'hff00, 1'b0, 2, EXC_ILL_ADDR);
    chk(base_freq, 16'h0032);
    chk({15'h0, run_coil}, 16'h0000);
  endtask

  initial
  begin
    repeat (8) @(negedge ref_clk);
    rst = 1'b0;
    chk(base_freq, BASE_FREQ_RST);
    chk({15'h0, tx_valid}, 16'h0000);
    t_coil_on();
    t_source();
    t_coil_off_slow();
    t_register();
    t_broadcast();
    t_dropped();
    t_exceptions();
    final_report();
  end
endmodule // testbench
